// ==== inc/pce_pkg.sv ====
// Constants and types for the port capability exchange block.
// Assumes a 200 MHz link-layer clock and an APB register bus.
package pce_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned T_PORT_CFG_US   = 20;
  localparam int unsigned T_PORT_CFG_CYC  = T_PORT_CFG_US * CLK_MHZ;
  localparam int unsigned TMR_W           = 13;

  localparam logic [11:0] REG_CTRL        = 12'h000;
  localparam logic [11:0] REG_STATUS      = 12'h004;
  localparam logic [11:0] REG_SEED        = 12'h008;
  localparam logic [11:0] REG_PEER        = 12'h00c;

  localparam int unsigned CTRL_DIR_LSB    = 0;
  localparam int unsigned CTRL_OTG_BIT    = 2;
  localparam int unsigned CTRL_EN_BIT     = 3;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0009;
  localparam logic [15:0] SEED_RST        = 16'hace1;

  localparam int unsigned ST_ROLE_DFP     = 8;
  localparam int unsigned ST_ROLE_UFP     = 9;
  localparam int unsigned ST_ERR_BIT      = 10;
  localparam int unsigned ST_HANDOFF_BIT  = 11;
  localparam int unsigned ST_DONE_BIT     = 12;
  localparam int unsigned ST_TIES_LSB     = 16;

  localparam int unsigned LMP_TYPE_LSB    = 0;
  localparam logic [4:0]  LMP_TYPE_CODE   = 5'h00;
  localparam int unsigned SUBTYPE_LSB     = 5;
  localparam logic [3:0]  SUBTYPE_CAP     = 4'h4;
  localparam int unsigned SPEED_LSB       = 9;
  localparam logic [6:0]  SPEED_GEN1      = 7'h01;
  localparam int unsigned HPBUF_LSB       = 32;
  localparam logic [7:0]  HPBUF_GEN1      = 8'h04;
  localparam int unsigned DIR_LSB         = 48;
  localparam int unsigned OTG_BIT         = 50;
  localparam int unsigned TIE_LSB         = 52;

  localparam logic [15:0] LFSR_TAPS       = 16'hb400;

  typedef enum logic [5:0] {
    PCE_IDLE    = 6'b000001,
    PCE_SEND    = 6'b000010,
    PCE_WAIT    = 6'b000100,
    PCE_DONE    = 6'b001000,
    PCE_ERR     = 6'b010000,
    PCE_HANDOFF = 6'b100000
  } pce_state_t;

  typedef enum logic [1:0] {
    PCE_RES_DFP = 2'h0,
    PCE_RES_UFP = 2'h1,
    PCE_RES_BAD = 2'h2,
    PCE_RES_TIE = 2'h3
  } pce_res_t;
endpackage : pce_pkg

// ==== inc/pce_rng_if.sv ====
// Carrier between the exchange logic and its random source.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface pce_rng_if;
  logic [15:0] value;
  logic [15:0] seed;
  logic        seed_load;
  modport gen  (output value, input seed, input seed_load);
  modport user (input value, output seed, output seed_load);
endinterface : pce_rng_if

// ==== hdl/pce_lfsr.sv ====
// Free-running 16-bit LFSR used as the tiebreaker source.
// Assumes a seed loaded by software that differs per port.
`timescale 1ns/1ps
module pce_lfsr
  import pce_pkg::*;
(
  input  wire logic clk_in,   // Link-layer clock
  input  wire logic rst_in,   // Sync reset, active high
  pce_rng_if.gen    rng       // Seed in, value out
);
  typedef struct packed {
    logic [15:0] lfsr;
  } pce_lfsr_s_t;

  pce_lfsr_s_t s_q;
  pce_lfsr_s_t s_d;

  always_comb begin
    s_d = s_q;
    if (rng.seed_load) begin
      // All-zero seed would lock the register up
      s_d.lfsr = (rng.seed == 16'h0000) ? 16'h0001 : rng.seed;
    end else if (s_q.lfsr[0]) begin
      s_d.lfsr = (s_q.lfsr >> 1) ^ LFSR_TAPS;
    end else begin
      s_d.lfsr = s_q.lfsr >> 1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q.lfsr <= SEED_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rng.value = s_q.lfsr;
endmodule : pce_lfsr

// ==== hdl/pce_top.sv ====
// Port capability exchange: builds, sends and parses the capability
// packet, then resolves the downstream-facing role.
// Assumes the link layer appends and checks the CRC and gives a U0 level.
//
// Functional notes
// - Send capability packet before the configuration timeout after reaching U0.
// - Send capability packet at once on every U0 entry.
// - Downstream-capable port flags an error when partner packet times out.
// - Upstream-only port hands off on timeout, no error.
// - Four-bit subtype at dword 0 bit 5 carries capability code.
// - Capability subtype is 0100b; receivers recognise packets by it.
// - Gen 1: speed mask at dword 0 bit 9, bit 0 set.
// - Not Gen 1: speed mask and buffer count sent as zero.
// - Gen 1: buffer count at dword 1 bit 0 reports four.
// - Direction at dword 1 bit 16; at least one bit set. The CTRL direction bits are sent as written, so 00 is not blocked.
// - OTG flag at dword 1 bit 18 reflects OTG support.
// - Tiebreaker at dword 1 bit 20 is zero unless dual.
// - After both packets, decide roles from both direction fields.
// - Role matrix: single-capability ports resolve, like pairs undefined.
// - Dual pair: higher tiebreaker becomes downstream.
// - Equal tiebreakers: resend with a new, different tiebreaker.
// - Tiebreaker sequence comes from a random source.
// - CRC covers the first twelve bytes; check before using fields.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module pce_top
  import pce_pkg::*;
(
  input  wire logic        clk_in,          // Link-layer clock, 200 MHz
  input  wire logic        rst_in,          // Sync reset, active high
  input  wire logic [11:0] paddr_in,        // APB address
  input  wire logic        psel_in,         // APB select
  input  wire logic        penable_in,      // APB enable
  input  wire logic        pwrite_in,       // APB write
  input  wire logic [31:0] pwdata_in,       // APB write data
  output logic      [31:0] prdata_out,      // APB read data
  output logic             pready_out,      // APB ready
  output logic             pslverr_out,     // APB error, unmapped address
  input  wire logic        link_u0_in,      // Link in U0, level
  input  wire logic        link_gen1_in,    // Link at Gen 1 speed, level
  input  wire logic        rx_valid_in,     // Received packet strobe
  input  wire logic [95:0] rx_data_in,      // Received dwords 0..2
  input  wire logic        rx_crc_ok_in,    // CRC of received packet good
  input  wire logic        tx_ready_in,     // Link layer takes tx packet
  output logic             tx_valid_out,    // Tx packet pending
  output logic      [95:0] tx_data_out,     // Tx dwords 0..2, CRC added later
  output logic             role_dfp_out,    // Resolved downstream-facing
  output logic             role_ufp_out,    // Resolved upstream-facing
  output logic             cfg_err_out,     // Capability error, level
  output logic             ufp_handoff_out  // Upstream-only timeout handoff
);
  typedef struct packed {
    pce_state_t        st;
    logic [TMR_W-1:0]  timer;
    logic              sent;
    logic              got;
    logic [31:0]       peer_dw1;
    logic [3:0]        tie;
    logic [7:0]        ties;
    logic              tx_valid;
    logic [95:0]       tx_data;
    logic              dfp;
    logic              ufp;
    logic              err;
    logic              handoff;
    logic [31:0]       ctrl;
    logic [15:0]       seed;
    logic              seed_load;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } pce_top_s_t;

  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(T_PORT_CFG_CYC - 1);

  pce_top_s_t s_q;
  pce_top_s_t s_d;
  pce_rng_if  rng ();

  pce_lfsr u_lfsr (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .rng    (rng.gen)
  );

  assign rng.seed      = s_q.seed;
  assign rng.seed_load = s_q.seed_load;

  // Reserved fields stay zero because the vector starts cleared
  function automatic logic [95:0] build_cap(input logic [1:0] dir,
                                            input logic       otg,
                                            input logic       gen1,
                                            input logic [3:0] tie);
    logic [95:0] p;
    p = 96'h0;
    p[LMP_TYPE_LSB +: 5] = LMP_TYPE_CODE;
    p[SUBTYPE_LSB +: 4]  = SUBTYPE_CAP;
    if (gen1) begin
      p[SPEED_LSB +: 7] = SPEED_GEN1;
      p[HPBUF_LSB +: 8] = HPBUF_GEN1;
    end
    p[DIR_LSB +: 2] = dir;
    p[OTG_BIT]      = otg;
    // Left at zero unless both roles are offered
    if (dir == 2'b11) begin
      p[TIE_LSB +: 4] = tie;
    end
    return p;
  endfunction : build_cap

  // Local direction l against peer direction p
  function automatic pce_res_t resolve(input logic [1:0] l,
                                       input logic [1:0] p,
                                       input logic [3:0] lt,
                                       input logic [3:0] pt);
    pce_res_t r;
    r = PCE_RES_BAD;
    unique case (l)
      2'b01: begin
        if (p[1]) begin
          r = PCE_RES_DFP;
        end else begin
          // Two downstream-only ports have no defined outcome
          r = PCE_RES_BAD;
        end
      end
      2'b10: begin
        if (p[0]) begin
          r = PCE_RES_UFP;
        end else begin
          r = PCE_RES_BAD;
        end
      end
      2'b11: begin
        if (p == 2'b10) begin
          r = PCE_RES_DFP;
        end else if (p == 2'b01) begin
          r = PCE_RES_UFP;
        end else if (p == 2'b11) begin
          if (lt > pt) begin
            r = PCE_RES_DFP;
          end else if (lt < pt) begin
            r = PCE_RES_UFP;
          end else begin
            r = PCE_RES_TIE;
          end
        end else begin
          r = PCE_RES_BAD;
        end
      end
      2'b00: r = PCE_RES_BAD;
    endcase
    return r;
  endfunction : resolve

  // New tiebreaker, forced away from the previous one
  function automatic logic [3:0] next_tie(input logic [3:0] rnd,
                                          input logic [3:0] prev);
    if (rnd == prev) begin
      return rnd ^ 4'h1;
    end
    return rnd;
  endfunction : next_tie

  // Only a CRC-clean link management packet of our subtype counts
  function automatic logic is_cap_pkt(input logic        ok,
                                      input logic [31:0] dw0);
    return ok && (dw0[LMP_TYPE_LSB +: 5] == LMP_TYPE_CODE) &&
           (dw0[SUBTYPE_LSB +: 4] == SUBTYPE_CAP);
  endfunction : is_cap_pkt

  // Status word as software reads it
  function automatic logic [31:0] status_word(input pce_top_s_t s);
    logic [31:0] w;
    w                   = 32'h0;
    w[5:0]              = s.st;
    w[ST_ROLE_DFP]      = s.dfp;
    w[ST_ROLE_UFP]      = s.ufp;
    w[ST_ERR_BIT]       = s.err;
    w[ST_HANDOFF_BIT]   = s.handoff;
    w[ST_DONE_BIT]      = (s.st == PCE_DONE);
    w[ST_TIES_LSB +: 8] = s.ties;
    return w;
  endfunction : status_word

  // Read mux; bit 32 flags an unmapped address
  function automatic logic [32:0] rd_word(input logic [11:0] a,
                                          input pce_top_s_t  s);
    logic [32:0] w;
    w = 33'h0;
    unique case (a)
      REG_CTRL:   w[31:0] = s.ctrl;
      REG_STATUS: w[31:0] = status_word(s);
      REG_SEED:   w[15:0] = s.seed;
      REG_PEER:   w[31:0] = s.peer_dw1;
      default:    w[32]   = 1'b1;
    endcase
    return w;
  endfunction : rd_word

  logic [1:0] loc_dir;
  logic       loc_otg;
  logic       enable;
  logic       rx_cap;
  logic       apb_acc;
  logic       apb_wr;
  pce_res_t   res;
  logic [3:0] tie_new;

  always_comb begin
    loc_dir = s_q.ctrl[CTRL_DIR_LSB +: 2];
    loc_otg = s_q.ctrl[CTRL_OTG_BIT];
    enable  = s_q.ctrl[CTRL_EN_BIT];
    rx_cap  = rx_valid_in && is_cap_pkt(rx_crc_ok_in, rx_data_in[31:0]);
    apb_acc = psel_in && penable_in && !s_q.pready;
    apb_wr  = psel_in && penable_in && s_q.pready && pwrite_in;
    res     = resolve(loc_dir, s_q.peer_dw1[DIR_LSB-32 +: 2], s_q.tie,
                      s_q.peer_dw1[TIE_LSB-32 +: 4]);
    tie_new = next_tie(rng.value[3:0], s_q.tie);
  end

  always_comb begin
    s_d = s_q;
    s_d.seed_load = 1'b0;

    // APB slave: one wait state, answer in second access cycle
    s_d.pready  = apb_acc;
    s_d.pslverr = 1'b0;
    if (apb_acc) begin
      // Loaded once per access, so read data is a plain flop at the pins
      {s_d.pslverr, s_d.prdata} = rd_word(paddr_in, s_q);
    end
    if (apb_wr) begin
      if (paddr_in == REG_CTRL) begin
        s_d.ctrl = {28'h0, pwdata_in[3:0]};
      end else if (paddr_in == REG_SEED) begin
        s_d.seed      = pwdata_in[15:0];
        s_d.seed_load = 1'b1;
      end
    end

    // Partner packet may arrive before ours is sent
    if ((s_q.st == PCE_SEND || s_q.st == PCE_WAIT) && rx_cap) begin
      s_d.got      = 1'b1;
      s_d.peer_dw1 = rx_data_in[63:32];
    end
    if (s_q.tx_valid && tx_ready_in) begin
      s_d.tx_valid = 1'b0;
      s_d.sent     = 1'b1;
    end

    unique case (s_q.st)
      PCE_IDLE: begin
        if (link_u0_in && enable) begin
          s_d.st       = PCE_SEND;
          s_d.timer    = '0;
          s_d.sent     = 1'b0;
          s_d.got      = 1'b0;
          s_d.dfp      = 1'b0;
          s_d.ufp      = 1'b0;
          s_d.err      = 1'b0;
          s_d.handoff  = 1'b0;
          s_d.ties     = 8'h00;
          s_d.tie      = tie_new;
          s_d.tx_valid = 1'b1;
          s_d.tx_data  = build_cap(loc_dir, loc_otg, link_gen1_in, tie_new);
        end
      end
      PCE_SEND, PCE_WAIT: begin
        // Runs from U0 entry or from the last tie restart
        s_d.timer = s_q.timer + 1'b1;
        if (s_q.tx_valid && tx_ready_in) begin
          s_d.st = PCE_WAIT;
        end
        if (s_q.sent && s_q.got) begin
          unique case (res)
            PCE_RES_DFP: begin
              s_d.st  = PCE_DONE;
              s_d.dfp = 1'b1;
            end
            PCE_RES_UFP: begin
              s_d.st  = PCE_DONE;
              s_d.ufp = 1'b1;
            end
            PCE_RES_BAD: begin
              s_d.st  = PCE_ERR;
              s_d.err = 1'b1;
            end
            PCE_RES_TIE: begin
              s_d.st       = PCE_SEND;
              s_d.timer    = '0;
              s_d.sent     = 1'b0;
              s_d.got      = 1'b0;
              s_d.ties     = s_q.ties + 1'b1;
              s_d.tie      = tie_new;
              s_d.tx_valid = 1'b1;
              s_d.tx_data  = build_cap(loc_dir, loc_otg, link_gen1_in, tie_new);
            end
          endcase
        end else if (s_q.timer == TMR_LAST && !s_q.got) begin
          if (loc_dir[0]) begin
            s_d.st  = PCE_ERR;
            s_d.err = 1'b1;
          end else begin
            s_d.st      = PCE_HANDOFF;
            s_d.handoff = 1'b1;
          end
        end else if (s_q.timer == TMR_LAST) begin
          // Our packet was never taken; give up rather than hang
          s_d.st       = PCE_ERR;
          s_d.err      = 1'b1;
          s_d.tx_valid = 1'b0;
        end
      end
      PCE_DONE, PCE_ERR, PCE_HANDOFF: begin
      end
      default: s_d.st = PCE_IDLE;
    endcase

    // Leaving U0 abandons the exchange; re-entry restarts it
    if (!link_u0_in || !enable) begin
      s_d.st       = PCE_IDLE;
      s_d.tx_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '{st: PCE_IDLE, ctrl: CTRL_RST, seed: SEED_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_out      = s_q.prdata;
  assign pready_out      = s_q.pready;
  assign pslverr_out     = s_q.pslverr;
  assign tx_valid_out    = s_q.tx_valid;
  assign tx_data_out     = s_q.tx_data;
  assign role_dfp_out    = s_q.dfp;
  assign role_ufp_out    = s_q.ufp;
  assign cfg_err_out     = s_q.err;
  assign ufp_handoff_out = s_q.handoff;
endmodule : pce_top

// ==== tb/pce_props.sv ====
// Checker on pce_top ports: packet fields, timeout, roles, APB wait state.
// Assumes CTRL enable stays set and gen1 only changes while U0 is low.
`timescale 1ns/1ps
module pce_props
  import pce_pkg::*;
(
  input wire logic        clk_in,         // Clock
  input wire logic        rst_in,         // Reset
  input wire logic        psel_in,        // APB select
  input wire logic        penable_in,     // APB enable
  input wire logic        pready_out,     // APB ready
  input wire logic        link_u0_in,     // U0 level
  input wire logic        link_gen1_in,   // Gen 1 speed
  input wire logic        rx_valid_in,    // Rx strobe
  input wire logic        rx_crc_ok_in,   // Rx CRC good
  input wire logic        tx_ready_in,    // Tx taken
  input wire logic        tx_valid_out,   // Tx pending
  input wire logic [95:0] tx_data_out,    // Tx packet
  input wire logic        role_dfp_out,   // Downstream
  input wire logic        role_ufp_out,   // Upstream
  input wire logic        cfg_err_out,    // Error
  input wire logic        ufp_handoff_out // Handoff
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic [12:0] age_q;
  logic        heard_q;
  // Age since U0; only judged while no good partner packet came
  always_ff @(posedge clk_in) begin
    if (rst_in || !link_u0_in) begin
      age_q   <= 13'h0;
      heard_q <= 1'b0;
    end else begin
      age_q   <= (age_q == 13'h1fff) ? age_q : age_q + 13'h1;
      heard_q <= heard_q | (rx_valid_in & rx_crc_ok_in);
    end
  end
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in;
  endsequence
  a_apb_wait: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
    else $error("APB ready not in second access cycle");
  a_tx_on_u0: assert property ($rose(link_u0_in) |=> tx_valid_out)
    else $error("No packet right after U0 entry");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in && link_u0_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("Packet dropped or changed before taken");
  a_subtype_code: assert property (tx_valid_out |-> tx_data_out[8:5] == 4'h4 && tx_data_out[4:0] == 5'h0)
    else $error("Bad subtype");
  a_speed_mask: assert property (tx_valid_out |-> tx_data_out[15:9] == (link_gen1_in ? 7'h01 : 7'h00))
    else $error("Bad speed mask");
  a_hp_buffers: assert property (tx_valid_out |-> tx_data_out[39:32] == (link_gen1_in ? 8'h04 : 8'h00))
    else $error("Bad buffer count");
  a_dir_set: assert property (tx_valid_out |-> tx_data_out[49:48] != 2'h0)
    else $error("Direction empty");
  a_tie_zero: assert property (tx_valid_out && tx_data_out[49:48] != 2'h3 |-> tx_data_out[55:52] == 4'h0)
    else $error("Tiebreaker set when not dual");
  a_rsvd_zero: assert property (tx_valid_out |-> tx_data_out[31:16] == 16'h0 && tx_data_out[47:40] == 8'h0
    && !tx_data_out[51] && tx_data_out[95:56] == 40'h0) else $error("Reserved bits set");
  a_one_outcome: assert property ($onehot0({role_dfp_out, role_ufp_out, cfg_err_out, ufp_handoff_out}))
    else $error("More than one outcome");
  a_timeout_age: assert property (($rose(cfg_err_out) || $rose(ufp_handoff_out)) && !heard_q
    |-> age_q >= T_PORT_CFG_CYC - 2 && age_q <= T_PORT_CFG_CYC + 3) else $error("Timeout at wrong time");
endmodule : pce_props
bind pce_top pce_props pce_props_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .link_u0_in(link_u0_in), .link_gen1_in(link_gen1_in),
  .rx_valid_in(rx_valid_in), .rx_crc_ok_in(rx_crc_ok_in), .tx_ready_in(tx_ready_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .role_dfp_out(role_dfp_out),
  .role_ufp_out(role_ufp_out), .cfg_err_out(cfg_err_out), .ufp_handoff_out(ufp_handoff_out));

// ==== tb/pce_peer.sv ====
// Link partner: takes our packet after a set stall, sends the bench's packet.
// Assumes one-cycle send requests from the bench.
`timescale 1ns/1ps
module pce_peer (
  input  wire logic        clk_in,       // Clock
  input  wire logic        tx_valid_in,  // Packet offered
  input  wire logic [95:0] tx_data_in,   // Offered packet
  input  wire logic [1:0]  stall_in,     // Ready delay
  input  wire logic        send_in,      // Send pkt_in
  input  wire logic [95:0] pkt_in,       // Our packet
  input  wire logic        crc_ok_in,    // CRC verdict
  output logic             tx_ready_out, // Taken
  output logic             rx_valid_out, // Packet strobe
  output logic      [95:0] rx_data_out,  // Packet
  output logic             rx_crc_ok_out,// CRC flag
  output logic      [95:0] got_out,      // Last taken
  output logic      [7:0]  n_got_out     // Taken count
);
  logic [1:0] wait_q = 2'h0;
  initial {tx_ready_out, rx_valid_out, rx_data_out, rx_crc_ok_out, got_out, n_got_out} = '0;
  always @(posedge clk_in) begin
    rx_valid_out  <= send_in;
    // Outside the strobe the lines change, so stale data never looks valid
    rx_data_out   <= send_in ? pkt_in : ~rx_data_out;
    rx_crc_ok_out <= send_in ? crc_ok_in : ~rx_crc_ok_out;
    if (tx_valid_in && tx_ready_out) begin
      got_out      <= tx_data_in;
      n_got_out    <= n_got_out + 8'h1;
      tx_ready_out <= 1'b0;
      wait_q       <= stall_in;
    end else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
    else if (tx_valid_in) tx_ready_out <= 1'b1;
  end
endmodule : pce_peer

// ==== tb/pce_top_tb.sv ====
// Bench for pce_top: registers over APB, role matrix, ties and timeouts.
// Assumes the block's one-wait-state APB and a 200 MHz clock.
`timescale 1ns/1ps
module pce_top_tb;
  import pce_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        u0 = 1'b0, gen1 = 1'b1, send = 1'b0, crc_ok = 1'b1, tx_ready, tx_valid, rx_valid, rx_ok;
  logic        dfp, ufp, err, hand;
  logic [95:0] tx_data, rx_data, got, pkt = '0;
  logic [1:0]  stall = 2'h0;
  logic [7:0]  n_got;
  int          err_count = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  pce_top pce_top_inst (.clk_in(clk), .rst_in(rst), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .link_u0_in(u0), .link_gen1_in(gen1), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_crc_ok_in(rx_ok),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data), .role_dfp_out(dfp),
    .role_ufp_out(ufp), .cfg_err_out(err), .ufp_handoff_out(hand));
  pce_peer pce_peer_inst (.clk_in(clk), .tx_valid_in(tx_valid), .tx_data_in(tx_data), .stall_in(stall),
    .send_in(send), .pkt_in(pkt), .crc_ok_in(crc_ok), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .rx_crc_ok_out(rx_ok), .got_out(got), .n_got_out(n_got));
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    int i;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    if (i == 20) chk(1, 0);
    r = {pslverr, prdata};
    {psel, pen} <= 2'h0;
    if (i == 20) wrap_up();
  endtask : apb
  task automatic tell(input logic [95:0] v, input logic ok);
    @(posedge clk);
    {pkt, crc_ok, send} <= {v, ok, 1'b1};
    @(posedge clk);
    send <= 1'b0;
  endtask : tell
  task automatic wait_tx(input logic [7:0] n0);
    int i;
    for (i = 0; i < 50 && n_got === n0; i++) @(posedge clk);
    if (n_got === n0) chk(1, 0);
    if (n_got === n0) wrap_up();
  endtask : wait_tx
  function automatic logic [95:0] mk(input logic [1:0] d, input logic o, g, input logic [3:0] t);
    logic [95:0] v;
    v = 96'h0;
    v[8:5] = 4'h4;
    v[15:9] = g ? 7'h01 : 7'h00;
    v[39:32] = g ? 8'h04 : 8'h00;
    v[50:48] = {o, d};
    v[55:52] = (d == 2'h3) ? t : 4'h0;
    return v;
  endfunction : mk
  function automatic logic [3:0] exp_role(input logic [1:0] l, p, input logic [3:0] lt, pt);
    if (l == p && l != 2'h3) return 4'h4;
    if (l == 2'h1 || p == 2'h2) return 4'h1;
    if (l == 2'h3 && p == 2'h3) return (lt > pt) ? 4'h1 : 4'h2;
    return 4'h2;
  endfunction : exp_role
  // Mode 0 plain, 1 equal tiebreakers, 2 silent partner, 3 bad CRC
  task automatic run(input logic [1:0] l, p, input logic o, g, input logic [1:0] mode);
    logic [32:0] r;
    logic [95:0] t;
    logic [3:0]  pt;
    logic [7:0]  n0;
    int          i;
    u0 <= 1'b0;
    apb(1'b1, 12'h000, {28'h0, 1'b1, o, l}, r);
    {gen1, stall} <= {g, 2'($urandom_range(3))};
    @(posedge clk);
    u0 <= 1'b1;
    wait_tx(n_got);
    t = got;
    chk(t, mk(l, o, g, t[55:52]));
    chk({hand, err, ufp, dfp}, 0);
    pt = (mode == 2'h1) ? t[55:52] : 4'($urandom);
    if (mode != 2'h1 && pt == t[55:52]) pt = ~pt;
    n0 = n_got;
    if (mode != 2'h2) tell(mk(p, 1'($urandom), g, pt), mode != 2'h3);
    if (mode == 2'h1) begin
      wait_tx(n0);
      chk(got[55:52] != t[55:52], 1);
      t = got;
      pt = ~t[55:52];
      tell(mk(p, 1'b0, g, pt), 1'b1);
    end
    for (i = 0; i < 4100 && {hand, err, ufp, dfp} === 4'h0; i++) @(posedge clk);
    chk({hand, err, ufp, dfp}, mode[1] ? (l[0] ? 4'h4 : 4'h8) : exp_role(l, p, t[55:52], pt));
    if ({hand, err, ufp, dfp} === 4'h0) wrap_up();
    apb(1'b0, 12'h00c, 32'h0, r);
    if (!mode[1]) chk(r, {1'b0, pkt[63:32]});
  endtask : run
  initial begin
    logic [32:0] r;
    int          k;
    void'($urandom(10));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, r);
    chk(r, 33'h9);
    apb(1'b0, 12'h008, 32'h0, r);
    chk(r[15:0], 16'hace1);
    apb(1'b1, 12'h004, 32'hffff, r);
    apb(1'b0, 12'h004, 32'h0, r);
    chk(r, 33'h1);
    apb(1'b1, 12'h010, 32'h5, r);
    chk(r[32], 1'b1);
    apb(1'b1, 12'h008, {16'h0, 16'($urandom)}, r);
    for (k = 0; k < 9; k++) run(2'(k / 3 + 1), 2'(k % 3 + 1), k[0], k[1], 2'h0);
    run(2'h3, 2'h3, 1'b0, 1'b1, 2'h1);
    for (k = 0; k < 6; k++) run(2'($urandom_range(3, 1)), 2'($urandom_range(3, 1)), 1'($urandom), 1'($urandom), 2'h0);
    run(2'h1, 2'h2, 1'b0, 1'b1, 2'h2);
    run(2'h2, 2'h1, 1'b1, 1'b0, 2'h2);
    run(2'h3, 2'h1, 1'b0, 1'b1, 2'h3);
    wrap_up();
  end
endmodule : pce_top_tb
